// File: logic/host_port_pkg.sv
// constants and types shared by the host port pin control block
// Functional notes
// R1 - host mode, strobe idle: data pins high impedance
// R2 - drive data only on strobe with read
// R3 - also drive on acknowledge during service request
// R4 - unselected port: data pins become gpio 0-7
// R5 - after reset all shared pins gpio inputs
// R6 - three address inputs choose target register
// R7 - unselected port: address pins become gpio 8-10
// R8 - unused port: direction pin becomes gpio 11
// R9 - host keeps direction stable during strobe
// R10 - write data captured at strobe rising edge
`default_nettype none
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int GPIO_W = 12;
    localparam int GPIO_DATA_LSB = 0;
    localparam int GPIO_ADDR_LSB = 8;
    localparam int GPIO_DIR_BIT = 11;
    localparam logic [GPIO_W-1:0] GPIO_OE_RST = 12'h000;
    localparam logic [GPIO_W-1:0] GPIO_OUT_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
    localparam int BUF_DEPTH = 2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } access_state_t;
endpackage
`default_nettype wire

// File: logic/host_word_buffer.sv
// two-entry buffer carrying captured host write words
`timescale 1ns/10ps
`default_nettype none
module host_word_buffer
    import host_port_pkg::*;
#(
    parameter int WIDTH = DATA_W + ADDR_W
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    logic [WIDTH-1:0] mem_q [BUF_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_in_ready = (count_q != 2'(BUF_DEPTH));
    assign o_out_valid = (count_q != 2'h0);
    assign o_out_data = mem_q[rd_ptr_q];

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) wr_ptr_q <= ~wr_ptr_q;
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + 2'(push) - 2'(pop);
        end
    end
endmodule
`default_nettype wire

// File: logic/host_port_pin_control.sv
// pin control for the parallel host port and its shared gpio pins
`timescale 1ns/10ps
`default_nettype none
module host_port_pin_control
    import host_port_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // port mode
    input wire logic i_host_port_select,
    // host pins
    input wire logic [DATA_W-1:0] i_host_data_bus,
    output logic [DATA_W-1:0] o_host_data_bus,
    output logic [DATA_W-1:0] o_host_data_bus_oe,
    input wire logic i_host_strobe_n,
    input wire logic i_host_dir_select,
    input wire logic [ADDR_W-1:0] i_host_reg_select,
    input wire logic i_host_ack_in_n,
    // service request state from the rest of the port
    input wire logic i_host_service_request_n,
    // read data from the port registers
    output logic [ADDR_W-1:0] o_rd_reg_select,
    output logic o_rd_active,
    input wire logic [DATA_W-1:0] i_rd_data,
    // captured write words towards the port registers
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output logic [ADDR_W-1:0] o_wr_reg_select,
    output logic [DATA_W-1:0] o_wr_data,
    // host side overrun flag: a write that found the buffer full and was dropped
    output logic o_wr_overrun,
    // general purpose pins 0-11
    input wire logic [GPIO_W-1:0] i_gpio_out,
    input wire logic [GPIO_W-1:0] i_gpio_oe,
    output logic [GPIO_W-1:0] o_gpio_pin_out,
    output logic [GPIO_W-1:0] o_gpio_pin_oe,
    output logic [GPIO_W-1:0] o_gpio_in
);
    access_state_t state_q;
    logic strobe_q;
    logic [DATA_W-1:0] wdata_q;
    logic [ADDR_W-1:0] waddr_q;
    logic push_q;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [DATA_W+ADDR_W-1:0] buf_out_data;
    logic strobe_act;
    logic host_drive;
    logic [GPIO_W-1:0] shared_pins;

    assign strobe_act = !i_host_strobe_n;
    // read on strobe, or acknowledge while our request is asserted
    assign host_drive = (strobe_act && i_host_dir_select) // R2
        || (!i_host_ack_in_n && !i_host_service_request_n); // R3
    assign shared_pins = {i_host_dir_select, i_host_reg_select, i_host_data_bus};

    // access tracker; direction is latched at strobe start since the host holds it
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
        end else if (!i_host_port_select) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (strobe_act) state_q <= i_host_dir_select ? ST_READ : ST_WRITE; // R9
                end
                ST_READ, ST_WRITE: begin
                    if (!strobe_act) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // sample data and address while the write strobe is low; last sample wins
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strobe_q <= 1'b0;
            wdata_q <= DATA_RST;
            waddr_q <= ADDR_RST;
        end else begin
            strobe_q <= strobe_act && i_host_port_select;
            if (strobe_act && !i_host_dir_select && i_host_port_select) begin
                wdata_q <= i_host_data_bus;
                waddr_q <= i_host_reg_select; // R6
            end
        end
    end

    // word committed on the strobe rising edge
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            push_q <= 1'b0;
            o_wr_overrun <= 1'b0;
        end else begin
            push_q <= strobe_q && !strobe_act && (state_q == ST_WRITE); // R10
            // the word is lost at the push edge, so judge fullness there
            o_wr_overrun <= push_q && !buf_in_ready;
        end
    end

    host_word_buffer u_buf (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_in_valid(push_q),
        .o_in_ready(buf_in_ready),
        .i_in_data({waddr_q, wdata_q}),
        .o_out_valid(buf_out_valid),
        .i_out_ready(!o_wr_valid || i_wr_ready),
        .o_out_data(buf_out_data)
    );

    // output stage register so the drain ports come from flops
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wr_valid <= 1'b0;
            o_wr_reg_select <= ADDR_RST;
            o_wr_data <= DATA_RST;
        end else if (!o_wr_valid || i_wr_ready) begin
            o_wr_valid <= buf_out_valid;
            o_wr_reg_select <= buf_out_data[DATA_W+ADDR_W-1:DATA_W];
            o_wr_data <= buf_out_data[DATA_W-1:0];
        end
    end

    // host data pin drivers; one cycle of pin latency from the flop stage
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_host_data_bus_oe <= '0; // R5
            o_host_data_bus <= DATA_RST;
            o_rd_reg_select <= ADDR_RST;
            o_rd_active <= 1'b0;
        end else begin
            o_host_data_bus_oe <= (i_host_port_select && host_drive)
                ? {DATA_W{1'b1}} : {DATA_W{1'b0}}; // R1 R2 R3
            o_host_data_bus <= i_rd_data;
            o_rd_reg_select <= i_host_reg_select; // R6
            o_rd_active <= i_host_port_select && host_drive;
        end
    end

    // shared pins go to gpio bits 0-11 when the host port is not selected
    generate
        for (genvar b = 0; b < GPIO_W; b++) begin : g_gpio
            always_ff @(posedge i_sys_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_gpio_pin_oe[b] <= GPIO_OE_RST[b]; // R5
                    o_gpio_pin_out[b] <= GPIO_OUT_RST[b];
                    o_gpio_in[b] <= 1'b0;
                end else begin
                    o_gpio_pin_oe[b] <= !i_host_port_select && i_gpio_oe[b]; // R4 R7 R8
                    o_gpio_pin_out[b] <= i_gpio_out[b];
                    o_gpio_in[b] <= i_host_port_select ? 1'b0 : shared_pins[b]; // R4 R7 R8
                end
            end
        end
    endgenerate

    // assertions
    property p_tristate_idle;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_host_port_select && i_host_strobe_n && i_host_ack_in_n)
            |=> (o_host_data_bus_oe == '0);
    endproperty
    a_tristate_idle: assert property (p_tristate_idle) else $error("data pins driven while idle"); // R1

    property p_read_drive;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_host_port_select && !i_host_strobe_n && i_host_dir_select)
            |=> (o_host_data_bus_oe == {DATA_W{1'b1}});
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read strobe did not drive"); // R2

    property p_write_input;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (!i_host_strobe_n && !i_host_dir_select && (i_host_ack_in_n || i_host_service_request_n))
            |=> (o_host_data_bus_oe == '0);
    endproperty
    a_write_input: assert property (p_write_input) else $error("driven during write"); // R2

    property p_ack_drive;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_host_port_select && !i_host_ack_in_n && !i_host_service_request_n)
            |=> (o_host_data_bus_oe == {DATA_W{1'b1}});
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack did not drive"); // R3

    property p_gpio_release;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        i_host_port_select |=> (o_gpio_pin_oe == '0) && (o_host_data_bus_oe == '0 || $past(host_drive));
    endproperty
    a_gpio_release: assert property (p_gpio_release) else $error("gpio drives in host mode"); // R4

    property p_gpio_addr;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_resetn && !i_host_port_select)
            |=> (o_gpio_in[GPIO_ADDR_LSB +: ADDR_W] == $past(i_host_reg_select))
            && (o_host_data_bus_oe == '0);
    endproperty
    a_gpio_addr: assert property (p_gpio_addr) else $error("address pins not on gpio"); // R7

    property p_gpio_data;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_resetn && !i_host_port_select)
            |=> (o_gpio_in[GPIO_DATA_LSB +: DATA_W] == $past(i_host_data_bus));
    endproperty
    a_gpio_data: assert property (p_gpio_data) else $error("data pins not on gpio"); // R4

    property p_gpio_dir;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (i_resetn && !i_host_port_select)
            |=> (o_gpio_in[GPIO_DIR_BIT] == $past(i_host_dir_select));
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("direction pin not on gpio"); // R8

    sequence s_write_strobe;
        i_host_port_select && !i_host_strobe_n && !i_host_dir_select ##1
        i_host_port_select && !i_host_strobe_n && !i_host_dir_select;
    endsequence
    sequence s_strobe_rise;
        i_host_strobe_n && i_host_port_select;
    endsequence
    property p_capture;
        @(posedge i_sys_clk) disable iff (!i_resetn)
        (s_write_strobe ##1 s_strobe_rise) |=> push_q ##0 (wdata_q == $past(i_host_data_bus, 2));
    endproperty
    a_capture: assert property (p_capture) else $error("write not captured at strobe rise"); // R10
endmodule
`default_nettype wire

// File: testbench/host_side_model.sv
// behavioural host processor driving the parallel host port pins
`timescale 1ns/10ps
`default_nettype none
module host_side_model
    import host_port_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // device pins
    input wire logic [DATA_W-1:0] i_dev_data,
    input wire logic [DATA_W-1:0] i_dev_data_oe,
    output logic [DATA_W-1:0] o_data_bus,
    output logic o_strobe_n,
    output logic o_dir_select,
    output logic [ADDR_W-1:0] o_reg_select,
    output logic o_ack_n
);
    logic drive_q = 1'b0;
    logic [DATA_W-1:0] wdata_q = 8'h00;
    logic [DATA_W-1:0] last_q = 8'h00;
    initial begin
        o_strobe_n = 1'b1;
        o_dir_select = 1'b1;
        o_reg_select = 3'h0;
        o_ack_n = 1'b1;
    end
    // released bus shows a changing pattern, not a stale value
    // unknown enable before reset counts as released, so no unknown gets latched
    assign o_data_bus = (i_dev_data_oe[0] === 1'b1) ? i_dev_data
        : (drive_q ? wdata_q : ~last_q);
    always @(posedge i_sys_clk) last_q <= o_data_bus;
    task automatic pins(input logic dir, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_sys_clk);
        o_dir_select <= dir;
        o_reg_select <= a;
        wdata_q <= d;
        drive_q <= ~dir;
    endtask
    task automatic start(input logic dir, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        pins(dir, a, d);
        o_strobe_n <= 1'b0;
    endtask
    task automatic finish();
        @(posedge i_sys_clk);
        o_strobe_n <= 1'b1;
        @(posedge i_sys_clk);
        drive_q <= 1'b0;
    endtask
    task automatic ack(input logic level_n);
        @(posedge i_sys_clk);
        o_ack_n <= level_n;
    endtask
endmodule
`default_nettype wire

// File: testbench/test_host_port_pin_control.sv
// self-checking testbench for the host port pin control block
`timescale 1ns/10ps
`default_nettype none
module test_host_port_pin_control;
    import host_port_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, req_n = 1'b1, wr_ready = 1'b0;
    logic [DATA_W-1:0] hd_in, hd_out, hd_oe, rd_data = 8'h00, wr_data;
    logic strobe_n, dir, ack_n, rd_active, wr_valid, overrun;
    logic [ADDR_W-1:0] reg_sel, rd_sel, wr_sel;
    logic [GPIO_W-1:0] g_out = 12'h000, g_oe = 12'h000, g_pin_out, g_pin_oe, g_in;
    int errors = 0, samples_checked = 0, overruns = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (overrun === 1'b1) overruns++;
    host_side_model u_host (.i_sys_clk(clk), .i_dev_data(hd_out), .i_dev_data_oe(hd_oe),
        .o_data_bus(hd_in), .o_strobe_n(strobe_n), .o_dir_select(dir),
        .o_reg_select(reg_sel), .o_ack_n(ack_n));
    host_port_pin_control DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_host_port_select(sel),
        .i_host_data_bus(hd_in), .o_host_data_bus(hd_out), .o_host_data_bus_oe(hd_oe),
        .i_host_strobe_n(strobe_n), .i_host_dir_select(dir), .i_host_reg_select(reg_sel),
        .i_host_ack_in_n(ack_n), .i_host_service_request_n(req_n), .o_rd_reg_select(rd_sel),
        .o_rd_active(rd_active), .i_rd_data(rd_data), .o_wr_valid(wr_valid),
        .i_wr_ready(wr_ready), .o_wr_reg_select(wr_sel), .o_wr_data(wr_data),
        .o_wr_overrun(overrun), .i_gpio_out(g_out), .i_gpio_oe(g_oe),
        .o_gpio_pin_out(g_pin_out), .o_gpio_pin_oe(g_pin_oe), .o_gpio_in(g_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drain(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int i;
        for (i = 0; i < 20 && wr_valid !== 1'b1; i++) cycles(1);
        if (i == 20) begin
            errors++;
            stop_test();
        end
        check(wr_sel, a);
        check(wr_data, d);
        @(posedge clk) wr_ready <= 1'b1;
        @(posedge clk) wr_ready <= 1'b0;
        #1;
    endtask
    task automatic gpio_mode_scenario();
        @(posedge clk) begin
            sel <= 1'b0;
            g_out <= 12'hA5C;
            g_oe <= 12'h3F1;
        end
        u_host.start(1'b1, 3'h5, 8'h00);
        cycles(3);
        check(hd_oe, 8'h00);
        check(g_in[11], 1'b1);
        check(g_in[10:8], 3'h5);
        check(g_pin_oe, 12'h3F1);
        check(g_pin_out, 12'hA5C);
        u_host.finish();
        u_host.pins(1'b0, 3'h2, 8'h96);
        cycles(3);
        check(g_in, {1'b0, 3'h2, 8'h96});
    endtask
    task automatic read_scenario(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk) begin
            sel <= 1'b1;
            rd_data <= d;
        end
        cycles(2);
        check(hd_oe, 8'h00);
        u_host.start(1'b1, a, 8'h00);
        cycles(2);
        check(hd_oe, 8'hFF);
        check(hd_out, d);
        check(rd_sel, a);
        check(rd_active, 1'b1);
        check(g_pin_oe, 12'h000);
        check(g_in, 12'h000);
        u_host.finish();
        cycles(1);
        check(hd_oe, 8'h00);
    endtask
    task automatic write_scenario();
        u_host.start(1'b0, 3'h3, 8'h5A);
        cycles(2);
        check(hd_oe, 8'h00);
        u_host.finish();
        drain(3'h3, 8'h5A);
    endtask
    task automatic overrun_scenario();
        logic [DATA_W-1:0] d;
        for (int k = 0; k < 4; k++) begin
            d = 8'(8'h11 * (k + 1));
            u_host.start(1'b0, k[2:0], d);
            @(posedge clk);
            u_host.finish();
        end
        cycles(6);
        check(16'(overruns), 16'h0001);
        drain(3'h0, 8'h11);
        drain(3'h1, 8'h22);
        drain(3'h2, 8'h33);
        cycles(3);
        check(wr_valid, 1'b0);
    endtask
    task automatic ack_scenario();
        u_host.ack(1'b0);
        cycles(3);
        check(hd_oe, 8'h00);
        @(posedge clk) req_n <= 1'b0;
        cycles(2);
        check(hd_oe, 8'hFF);
        u_host.ack(1'b1);
        cycles(2);
        check(hd_oe, 8'h00);
        @(posedge clk) req_n <= 1'b1;
    endtask
    initial begin
        cycles(9);
        check({g_pin_oe, hd_oe[3:0]}, 16'h0000);
        @(posedge clk) rstn <= 1'b1;
        cycles(1);
        check(g_pin_oe, 12'h000);
        check(hd_oe, 8'h00);
        gpio_mode_scenario();
        read_scenario(3'h6, 8'h3C);
        read_scenario(3'h1, 8'hC3);
        write_scenario();
        overrun_scenario();
        ack_scenario();
        stop_test();
    end
endmodule
`default_nettype wire
